// ---- dv/aopc_assertions.sv ----
// Purpose: Port-level checks for the converter output block
// Assumes: Bound to aopc_top; pclk and sample_clk domains
// Notes:   Register outputs get two pclk cycles to follow a write; power-down enables get three
`timescale 1ns/1ns

module aopc_checker
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        sample_clk,
	input wire logic        output_sample_bits_en,
	input wire logic        output_data_clock,
	input wire logic        output_data_clock_en,
	input wire logic        sample_valid,
	input wire logic        ref_enable,
	input wire logic        ref_buffer_enable,
	input wire logic        bias_enable,
	input wire logic        output_stage_enable,
	input wire logic        cm_buffer_connect,
	input wire logic [3:0]  full_scale_code,
	input wire logic        lvds_reduced_mode
);
	logic wr;

	assign wr = psel && penable && pwrite && pready;

	// ==========================================================
	// Register side
	property p_ready;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready && penable;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");

	property p_pd_off;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == aopc_pkg::ADDR_CONFIG && pwdata[1:0] != 2'h0 |-> ##3
		!ref_enable && !ref_buffer_enable && !bias_enable && !output_stage_enable;
	endproperty
	a_pd_off: assert property (p_pd_off) else $error("power-down left blocks on");

	property p_hiz;
		@(posedge pclk) disable iff (!presetn)
		$fell(output_stage_enable) |-> ##[1:40] !output_sample_bits_en && !output_data_clock_en;
	endproperty
	a_hiz: assert property (p_hiz) else $error("outputs still driven in power-down");

	property p_ext_ref;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == aopc_pkg::ADDR_ANALOG && pwdata[0] |=> ##[0:1] !ref_enable;
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("internal reference kept on");

	property p_cm;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == aopc_pkg::ADDR_ANALOG |-> ##2 cm_buffer_connect == !$past(pwdata[1], 2);
	endproperty
	a_cm: assert property (p_cm) else $error("common-mode buffer wrong");

	property p_lvds;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == aopc_pkg::ADDR_ANALOG |-> ##2 lvds_reduced_mode == $past(pwdata[2], 2);
	endproperty
	a_lvds: assert property (p_lvds) else $error("output mode wrong");

	property p_range;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == aopc_pkg::ADDR_RANGE |-> ##2 full_scale_code == $past(pwdata[3:0], 2);
	endproperty
	a_range: assert property (p_range) else $error("full-scale code wrong");

	// ==========================================================
	// Link side
	property p_ddr;
		@(posedge sample_clk) disable iff (!presetn)
		output_data_clock_en |=> output_data_clock != $past(output_data_clock);
	endproperty
	a_ddr: assert property (p_ddr) else $error("output clock missed a toggle");

	property p_vld;
		@(posedge sample_clk) disable iff (!presetn)
		!$rose(output_data_clock) |-> $stable(sample_valid);
	endproperty
	a_vld: assert property (p_vld) else $error("valid changed mid-word");
endmodule

bind aopc_top aopc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .sample_clk(sample_clk),
	.output_sample_bits_en(output_sample_bits_en), .output_data_clock(output_data_clock),
	.output_data_clock_en(output_data_clock_en), .sample_valid(sample_valid), .ref_enable(ref_enable),
	.ref_buffer_enable(ref_buffer_enable), .bias_enable(bias_enable),
	.output_stage_enable(output_stage_enable), .cm_buffer_connect(cm_buffer_connect),
	.full_scale_code(full_scale_code), .lvds_reduced_mode(lvds_reduced_mode));

// ---- dv/aopc_rx_model.sv ----
// Purpose: Receiver that captures the DDR lane into 16-bit words
// Assumes: Capture mid-bit, on the falling edge of the sample clock
// Notes:   Words are only counted while the sender marks them valid
`timescale 1ns/1ns

module aopc_rx_model
(
	input  wire logic       sample_clk,
	input  wire logic [7:0] lane,
	input  wire logic       lane_en,
	input  wire logic       dclk,
	input  wire logic       dclk_en,
	input  wire logic       sample_valid,
	output logic      [15:0] rx_word,
	output int              rx_count
);
	logic [7:0] pin;
	logic       dpin;
	logic [7:0] hi;

	// Released pins float: inverse keeps stale data from passing
	assign pin  = lane_en ? lane : ~lane;
	assign dpin = dclk_en ? dclk : ~dclk;

	initial rx_count = 0;

	// Edges are aligned with data, so capture half a cycle later
	always @(negedge sample_clk)
	begin
		if (dpin)
			hi <= pin;
		else if (sample_valid && lane_en)
		begin
			rx_word  <= {hi, pin};
			rx_count <= rx_count + 1;
		end
	end
endmodule

// ---- dv/test_adc_output_power_control.sv ----
// Purpose: Self-checking bench for the converter output block
// Assumes: Wake-up count shortened to 50 pclk cycles
// Notes:   Sample clock runs at 125 ns, unrelated to pclk
`timescale 1ns/1ns

module test_adc_output_power_control;
	localparam int WAKE = 50;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sample_clk;
	logic [15:0] converter_word;
	logic [7:0]  lane;
	logic        lane_en;
	logic        dclk;
	logic        dclk_en;
	logic        sample_valid;
	logic        ref_enable;
	logic        ref_buffer_enable;
	logic        bias_enable;
	logic        output_stage_enable;
	logic        cm_buffer_connect;
	logic [3:0]  full_scale_code;
	logic        lvds_reduced_mode;
	logic [15:0] rx_word;
	int          rx_count;
	logic [31:0] rd;
	logic        err;
	int          slow;
	int          miscompares;
	int          cmp_count;
	logic [7:0]  regs [4] = '{aopc_pkg::ADDR_CONFIG, aopc_pkg::ADDR_FORMAT, aopc_pkg::ADDR_RANGE,
		aopc_pkg::ADDR_ANALOG};
	logic [15:0] vals [5] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000, 16'h1234};

	aopc_top #(.WAKE_CYCLES(WAKE)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_clk(sample_clk), .converter_word(converter_word),
		.output_sample_bits(lane), .output_sample_bits_en(lane_en), .output_data_clock(dclk),
		.output_data_clock_en(dclk_en), .sample_valid(sample_valid), .ref_enable(ref_enable),
		.ref_buffer_enable(ref_buffer_enable), .bias_enable(bias_enable),
		.output_stage_enable(output_stage_enable), .cm_buffer_connect(cm_buffer_connect),
		.full_scale_code(full_scale_code), .lvds_reduced_mode(lvds_reduced_mode));

	aopc_rx_model u_rx (.sample_clk(sample_clk), .lane(lane), .lane_en(lane_en), .dclk(dclk),
		.dclk_en(dclk_en), .sample_valid(sample_valid), .rx_word(rx_word), .rx_count(rx_count));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Both phases stretched by slow to change the sample rate
	initial
	begin
		sample_clk = 1'b0;
		#17;
		forever
		begin
			sample_clk = ~sample_clk;
			#((sample_clk ? 62 : 63) + slow);
		end
	end

	// ==========================================================
	// Tasks
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
			miscompares++;
		end
	endtask

	task bound(input int n, input int lim);
		if (n >= lim)
		begin
			$display("mismatch at %0t: timeout", $time);
			miscompares++;
			test_done;
		end
	endtask

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		bound(n, 20);
	endtask

	task wait_rx(input int k);
		int c0;
		int n;
		c0 = rx_count;
		n = 0;
		while (rx_count < c0 + k && n < 4000)
		begin
			@(posedge pclk);
			n++;
		end
		bound(n, 4000);
	endtask

	function automatic logic [15:0] enc(input logic [1:0] f, input logic [15:0] w);
		if (f == 2'h1)
			return w ^ 16'h8000;
		if (f == 2'h2)
			return w ^ (w >> 1);
		return w;
	endfunction

	// ==========================================================
	// Main sequence
	initial
	begin
		int  n;
		time t0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		converter_word = 16'h8000;
		presetn = 1'b0;
		slow = 0;
		miscompares = 0;
		cmp_count = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (regs[i])
		begin
			xfer(1'b0, regs[i], 32'h0);
			chk(rd, 32'h0, "reset value");
		end
		xfer(1'b0, aopc_pkg::ADDR_STATUS, 32'h0);
		chk(rd & 32'h5, 32'h1, "status awake");
		chk(32'({ref_enable, ref_buffer_enable, bias_enable, output_stage_enable, cm_buffer_connect,
			lvds_reduced_mode, full_scale_code}), 32'h3E0, "analog reset");
		xfer(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0, "unmapped data");
		chk(32'(err), 32'h1, "unmapped error");
		$display("test reset done");

		for (int f = 0; f < 4; f++)
		begin
			xfer(1'b1, aopc_pkg::ADDR_FORMAT, 32'(f));
			foreach (vals[i])
			begin
				converter_word <= vals[i];
				wait_rx(6);
				chk(32'(rx_word), 32'(enc(2'(f), vals[i])), "coding");
			end
		end
		$display("test coding done");

		xfer(1'b1, aopc_pkg::ADDR_RANGE, 32'hF);
		xfer(1'b1, aopc_pkg::ADDR_ANALOG, 32'h7);
		xfer(1'b0, aopc_pkg::ADDR_ANALOG, 32'h0);
		chk(rd, 32'h7, "analog readback");
		chk(32'({ref_enable, cm_buffer_connect, lvds_reduced_mode, full_scale_code}), 32'h1F, "analog");
		xfer(1'b1, aopc_pkg::ADDR_ANALOG, 32'h0);
		xfer(1'b1, aopc_pkg::ADDR_RANGE, 32'h5);
		repeat (2) @(posedge pclk);
		chk(32'({ref_enable, cm_buffer_connect, lvds_reduced_mode, full_scale_code}), 32'h65, "range");
		$display("test analog done");

		xfer(1'b1, aopc_pkg::ADDR_CONFIG, 32'h2);
		n = 0;
		while (lane_en !== 1'b0 && n < 100)
		begin
			@(posedge pclk);
			n++;
		end
		bound(n, 100);
		chk(32'({dclk_en, ref_enable, ref_buffer_enable, bias_enable, output_stage_enable}), 32'h0, "down");
		xfer(1'b0, aopc_pkg::ADDR_STATUS, 32'h0);
		chk(rd & 32'h5, 32'h4, "status down");
		repeat (2) @(posedge sample_clk);
		chk(32'(sample_valid), 32'h0, "valid in down");
		t0 = $time;
		xfer(1'b1, aopc_pkg::ADDR_CONFIG, 32'h0);
		n = 0;
		do
		begin
			xfer(1'b0, aopc_pkg::ADDR_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b1 && n < 100);
		bound(n, 100);
		chk(32'($time - t0 >= WAKE * 40 && $time - t0 <= (WAKE + 12) * 40), 32'h1, "wake time");
		wait_rx(4);
		chk(32'(rx_word), 32'h1234, "after wake");
		$display("test power done");

		slow = 100;
		n = 0;
		while (sample_valid !== 1'b0 && n < 2000)
		begin
			@(posedge pclk);
			n++;
		end
		bound(n, 2000);
		xfer(1'b0, aopc_pkg::ADDR_STATUS, 32'h0);
		chk(32'(rd[1]), 32'h0, "relock status");
		slow = 0;
		wait_rx(4);
		chk(32'(rx_word), 32'h1234, "after relock");
		$display("test relock done");
		test_done;
	end
endmodule

// ---- hdl/aopc_pkg.sv ----
// Purpose: Shared constants and types for the converter output and power control block
// Assumes: APB byte addresses, 32-bit data, pclk at 25 MHz
// Notes:   Register fields sit in the low bits; the bits above read as zero
package aopc_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_CONFIG = 8'h08;
	localparam logic [7:0] ADDR_FORMAT = 8'h0C;
	localparam logic [7:0] ADDR_RANGE  = 8'h10;
	localparam logic [7:0] ADDR_ANALOG = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;

	// ==========================================================
	// Field layout and reset values
	localparam int         PD_LSB        = 0;
	localparam int         PD_MSB        = 1;
	localparam logic [1:0] PD_NORMAL     = 2'h0;
	localparam int         RANGE_W       = 4;
	localparam logic [3:0] RANGE_RESET   = 4'h0;
	localparam int         ANA_EXT_REF   = 0;
	localparam int         ANA_CM_OFF    = 1;
	localparam int         ANA_OUT_MODE  = 2;
	localparam logic [2:0] ANALOG_RESET  = 3'h0;
	localparam int         ST_AWAKE      = 0;
	localparam int         ST_LOCKED     = 1;
	localparam int         ST_DOWN       = 2;
	localparam int         WORD_W        = 16;
	localparam int         LANE_W        = 8;

	// ==========================================================
	// Timing
	localparam int PCLK_HZ        = 25_000_000;
	localparam int WAKE_TIME_MS   = 100;
	localparam int WAKE_CYCLES    = WAKE_TIME_MS * (PCLK_HZ / 1000);
	localparam int RELOCK_CYCLES  = 16;
	localparam int FREQ_DIV_W     = 4;
	localparam int MEAS_W         = 16;
	localparam logic [15:0] FREQ_TOL = 16'h0002;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		CODE_OFFSET,
		CODE_TWOS,
		CODE_GRAY,
		CODE_SPARE
	} aopc_coding_t;

	typedef struct packed {
		logic         pd;
		logic         awake;
		logic         relock_tag;
		aopc_coding_t coding;
	} aopc_ctrl_t;

	localparam aopc_ctrl_t CTRL_RESET = '{pd: 1'b0, awake: 1'b1, relock_tag: 1'b0, coding: CODE_OFFSET};

endpackage

// ---- hdl/aopc_top.sv ----
// Purpose: Output coding, DDR output framing and power-down control of a 16-bit converter
// Assumes: APB register access on pclk; converter words arrive on sample_clk
// Notes:   One sample of every two sample_clk cycles leaves as two bytes, one per output clock edge
//
// Functional notes
// [RULE1] Nonzero power-down field at 0x08 bits 1:0 enters power-down.
// [RULE2] Powered down: data and output clock drivers go high impedance.
// [RULE3] Powered down: reference, reference buffer, output stage and bias are off.
// [RULE4] About 100 ms wake-up after power-down release before samples count.
// [RULE5] Sample clock frequency change forces several cycles of relock; samples invalid.
// [RULE6] Internal timing regenerates the non-sampling edge for 50% duty.
// [RULE7] Offset binary after reset; twos complement or Gray selectable.
// [RULE8] Offset binary: all ones top, 0x8000 at zero, all zeros bottom.
// [RULE9] Data leaves with a forwarded clock, captured on both its edges.
// [RULE10] Full-scale 2.5 V after reset; register selects down to 2.0 V.
// [RULE11] A register bit disables the internal reference for the external pin.
// [RULE12] A register bit disconnects the input common-mode buffer.
// [RULE13] Outputs start in standard differential signalling mode after power-up.
// [RULE14] Samples taken on sample clock rising edge, pipelined.
// [RULE15] Twos complement inverts MSB; Gray is reflected code of offset binary.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ns

module aopc_top
#(
	parameter int unsigned WAKE_CYCLES = aopc_pkg::WAKE_CYCLES
)
(
	input  wire logic                               pclk,
	input  wire logic                               presetn,
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [7:0]                         paddr,
	input  wire logic [31:0]                        pwdata,
	output logic      [31:0]                        prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	input  wire logic                               sample_clk,
	input  wire logic [aopc_pkg::WORD_W-1:0]        converter_word,
	output logic      [aopc_pkg::LANE_W-1:0]        output_sample_bits,
	output logic                                    output_sample_bits_en,
	output logic                                    output_data_clock,
	output logic                                    output_data_clock_en,
	output logic                                    sample_valid,
	output logic                                    ref_enable,
	output logic                                    ref_buffer_enable,
	output logic                                    bias_enable,
	output logic                                    output_stage_enable,
	output logic                                    cm_buffer_connect,
	output logic      [aopc_pkg::RANGE_W-1:0]       full_scale_code,
	output logic                                    lvds_reduced_mode
);

	typedef enum logic [1:0] {
		PW_ON,
		PW_DOWN,
		PW_WAKE
	} aopc_pw_t;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == aopc_pkg::ADDR_CONFIG) || (a == aopc_pkg::ADDR_FORMAT) ||
			(a == aopc_pkg::ADDR_RANGE) || (a == aopc_pkg::ADDR_ANALOG) || (a == aopc_pkg::ADDR_STATUS);
	endfunction

	function automatic logic [15:0] encode(input logic [15:0] w, input aopc_pkg::aopc_coding_t c);
		case (c)
			aopc_pkg::CODE_TWOS: encode = {~w[15], w[14:0]};  // RULE15
			aopc_pkg::CODE_GRAY: encode = w ^ {1'b0, w[15:1]};  // RULE15
			default:             encode = w;                    // RULE8
		endcase
	endfunction

	// ==========================================================
	// APB slave
	logic [1:0]                  cfg_pd;
	aopc_pkg::aopc_coding_t      cfg_coding;
	logic [aopc_pkg::RANGE_W-1:0] cfg_range;
	logic [2:0]                  cfg_analog;
	aopc_pw_t                    pw_state;
	logic                        lock_p2;
	logic                        setup;
	logic                        wr;
	logic [31:0]                 next_prdata;

	assign setup = psel & ~penable;
	assign wr    = psel & penable & pready & pwrite;

	always_comb
	begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			aopc_pkg::ADDR_CONFIG: next_prdata[aopc_pkg::PD_MSB:aopc_pkg::PD_LSB] = cfg_pd;
			aopc_pkg::ADDR_FORMAT: next_prdata[1:0] = cfg_coding;
			aopc_pkg::ADDR_RANGE:  next_prdata[aopc_pkg::RANGE_W-1:0] = cfg_range;
			aopc_pkg::ADDR_ANALOG: next_prdata[2:0] = cfg_analog;
			aopc_pkg::ADDR_STATUS:
			begin
				next_prdata[aopc_pkg::ST_AWAKE]  = (pw_state == PW_ON);  // RULE4
				next_prdata[aopc_pkg::ST_LOCKED] = lock_p2;
				next_prdata[aopc_pkg::ST_DOWN]   = (pw_state == PW_DOWN);
			end
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	// One wait-free access cycle: answer is registered during setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~is_mapped(paddr);
			prdata  <= (setup & ~pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_pd     <= aopc_pkg::PD_NORMAL;
			cfg_coding <= aopc_pkg::CODE_OFFSET;           // RULE7
			cfg_range  <= aopc_pkg::RANGE_RESET;           // RULE10
			cfg_analog <= aopc_pkg::ANALOG_RESET;          // RULE13
		end
		else if (wr)
		begin
			case (paddr)
				aopc_pkg::ADDR_CONFIG: cfg_pd <= pwdata[aopc_pkg::PD_MSB:aopc_pkg::PD_LSB];  // RULE1
				aopc_pkg::ADDR_FORMAT: cfg_coding <= aopc_pkg::aopc_coding_t'(pwdata[1:0]);  // RULE7
				aopc_pkg::ADDR_RANGE:  cfg_range <= pwdata[aopc_pkg::RANGE_W-1:0];           // RULE10
				aopc_pkg::ADDR_ANALOG: cfg_analog <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Power state and wake-up timer
	logic [31:0] wake_cnt;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pw_state <= PW_ON;
			wake_cnt <= 32'h0000_0000;
		end
		else
		begin
			case (pw_state)
				PW_ON:
					if (cfg_pd != aopc_pkg::PD_NORMAL)
						pw_state <= PW_DOWN;  // RULE1
				PW_DOWN:
					if (cfg_pd == aopc_pkg::PD_NORMAL)
					begin
						pw_state <= PW_WAKE;
						wake_cnt <= WAKE_CYCLES - 1;  // RULE4
					end
				PW_WAKE:
					if (cfg_pd != aopc_pkg::PD_NORMAL)
						pw_state <= PW_DOWN;
					else if (wake_cnt == 32'h0000_0000)
						pw_state <= PW_ON;
					else
						wake_cnt <= wake_cnt - 32'h0000_0001;  // RULE4
				default: pw_state <= PW_ON;
			endcase
		end
	end

	// Analog enables follow the power state so they drop only once the state is committed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ref_enable          <= 1'b1;
			ref_buffer_enable   <= 1'b1;
			bias_enable         <= 1'b1;
			output_stage_enable <= 1'b1;
			cm_buffer_connect   <= 1'b1;
			full_scale_code     <= aopc_pkg::RANGE_RESET;
			lvds_reduced_mode   <= 1'b0;
		end
		else
		begin
			ref_enable          <= (pw_state != PW_DOWN) & ~cfg_analog[aopc_pkg::ANA_EXT_REF];  // RULE3 RULE11
			ref_buffer_enable   <= (pw_state != PW_DOWN);                                      // RULE3
			bias_enable         <= (pw_state != PW_DOWN);                                      // RULE3
			output_stage_enable <= (pw_state != PW_DOWN);                                      // RULE3
			cm_buffer_connect   <= ~cfg_analog[aopc_pkg::ANA_CM_OFF];                          // RULE12
			full_scale_code     <= cfg_range;                                                  // RULE10
			lvds_reduced_mode   <= cfg_analog[aopc_pkg::ANA_OUT_MODE];                         // RULE13
		end
	end

	// ==========================================================
	// Sample clock frequency watch
	logic                      ftg_s1;
	logic                      ftg_s2;
	logic                      ftg_s3;
	logic [aopc_pkg::MEAS_W-1:0] meas_cnt;
	logic [aopc_pkg::MEAS_W-1:0] meas_last;
	logic                      relock_tag;
	logic                      meas_armed;
	logic                      fdiv_tgl;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ftg_s1     <= 1'b0;
			ftg_s2     <= 1'b0;
			ftg_s3     <= 1'b0;
			meas_cnt   <= '0;
			meas_last  <= '0;
			meas_armed <= 1'b0;
			relock_tag <= 1'b0;
		end
		else
		begin
			ftg_s1 <= fdiv_tgl;
			ftg_s2 <= ftg_s1;
			ftg_s3 <= ftg_s2;
			if (ftg_s2 != ftg_s3)
			begin
				meas_cnt   <= '0;
				meas_armed <= 1'b1;
				// First interval starts at reset, not at a toggle: never compare it
				if (meas_armed)
					meas_last <= meas_cnt;
				// Period moved beyond sync jitter: request relock
				if ((meas_last != '0) && ((meas_cnt > meas_last + aopc_pkg::FREQ_TOL) ||
					(meas_last > meas_cnt + aopc_pkg::FREQ_TOL)))
					relock_tag <= ~relock_tag;  // RULE5
			end
			else if (meas_cnt != '1)
				meas_cnt <= meas_cnt + 1'b1;
		end
	end

	// ==========================================================
	// Control handshake into the sample clock domain
	aopc_pkg::aopc_ctrl_t ctrl_shadow;
	aopc_pkg::aopc_ctrl_t want;
	logic                 req_tgl;
	logic                 ack_tgl;
	logic                 ack_s1;
	logic                 ack_s2;
	logic                 lock_s;
	logic                 lock_p1;

	assign want = '{pd: (pw_state == PW_DOWN), awake: (pw_state == PW_ON), relock_tag: relock_tag,
		coding: cfg_coding};

	// Shadow only changes once the last word was taken, so it is stable when sampled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_shadow <= aopc_pkg::CTRL_RESET;
			req_tgl     <= 1'b0;
			ack_s1      <= 1'b0;
			ack_s2      <= 1'b0;
			lock_p1     <= 1'b0;
			lock_p2     <= 1'b0;
		end
		else
		begin
			ack_s1  <= ack_tgl;
			ack_s2  <= ack_s1;
			lock_p1 <= lock_s;
			lock_p2 <= lock_p1;
			if ((req_tgl == ack_s2) && (ctrl_shadow != want))
			begin
				ctrl_shadow <= want;
				req_tgl     <= ~req_tgl;
			end
		end
	end

	// ==========================================================
	// Sample clock domain
	logic                         srst_s1;
	logic                         srst_n;
	logic                         req_s1;
	logic                         req_s2;
	aopc_pkg::aopc_ctrl_t         ctrl_l;
	logic [aopc_pkg::WORD_W-1:0]  word_q;
	logic [aopc_pkg::LANE_W-1:0]  lo_q;
	logic [aopc_pkg::LANE_W-1:0]  next_lane;
	logic [aopc_pkg::WORD_W-1:0]  enc;
	logic                         phase;
	logic [aopc_pkg::FREQ_DIV_W-1:0] fdiv;
	logic [4:0]                   lock_cnt;

	always_ff @(posedge sample_clk or negedge presetn)
	begin
		if (!presetn)
		begin
			srst_s1 <= 1'b0;
			srst_n  <= 1'b0;
		end
		else
		begin
			srst_s1 <= 1'b1;
			srst_n  <= srst_s1;
		end
	end

	always_ff @(posedge sample_clk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			req_s1  <= 1'b0;
			req_s2  <= 1'b0;
			ack_tgl <= 1'b0;
			ctrl_l  <= aopc_pkg::CTRL_RESET;
		end
		else
		begin
			req_s1  <= req_tgl;
			req_s2  <= req_s1;
			ack_tgl <= req_s2;
			if (req_s2 != ack_tgl)
				ctrl_l <= ctrl_shadow;
		end
	end

	always_ff @(posedge sample_clk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			fdiv     <= '0;
			fdiv_tgl <= 1'b0;
		end
		else
		begin
			fdiv <= fdiv + 1'b1;
			if (fdiv == '1)
				fdiv_tgl <= ~fdiv_tgl;
		end
	end

	// Relock window after frequency change or wake-up
	always_ff @(posedge sample_clk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			lock_cnt <= 5'(aopc_pkg::RELOCK_CYCLES);
			lock_s   <= 1'b0;
		end
		else
		begin
			if ((req_s2 != ack_tgl) && (ctrl_shadow.relock_tag != ctrl_l.relock_tag))
				lock_cnt <= 5'(aopc_pkg::RELOCK_CYCLES);  // RULE5
			else if (!ctrl_l.awake)
				lock_cnt <= 5'(aopc_pkg::RELOCK_CYCLES);
			else if (lock_cnt != 5'h00)
				lock_cnt <= lock_cnt - 5'h01;
			lock_s <= (lock_cnt == 5'h00);
		end
	end

	assign enc = encode(word_q, ctrl_l.coding);

	genvar gi;
	generate
		for (gi = 0; gi < aopc_pkg::LANE_W; gi++)
		begin : g_lane
			assign next_lane[gi] = phase ? lo_q[gi] : enc[gi + aopc_pkg::LANE_W];
		end
	endgenerate

	// Output clock toggles on every rising sample_clk edge: duty set here, not by the input clock
	always_ff @(posedge sample_clk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			word_q                <= '0;
			lo_q                  <= '0;
			phase                 <= 1'b0;
			output_sample_bits    <= '0;
			output_sample_bits_en <= 1'b0;
			output_data_clock     <= 1'b0;
			output_data_clock_en  <= 1'b0;
			sample_valid          <= 1'b0;
		end
		else
		begin
			word_q                <= converter_word;                     // RULE14
			phase                 <= ~phase;
			output_sample_bits    <= next_lane;                          // RULE9
			output_data_clock     <= ~phase;                             // RULE6 RULE9
			output_sample_bits_en <= ~ctrl_l.pd;                         // RULE2
			output_data_clock_en  <= ~ctrl_l.pd;                         // RULE2
			if (!phase)
			begin
				lo_q         <= enc[aopc_pkg::LANE_W-1:0];
				sample_valid <= lock_s & ctrl_l.awake & ~ctrl_l.pd;  // RULE4 RULE5
			end
		end
	end

endmodule
